// [logic/fdcx_byte_mem.v]
// Byte store for command and result bytes.
// Assumes one writer; reads are registered, one cycle late.
`timescale 1ns/10ps
module fdcx_byte_mem #(
   parameter AW = 4,
   parameter DW = 8
) (
   // Clock
   input  wire          sys_clk,
   // Write port
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   // Read port for the host side
   input  wire [AW-1:0] raddr_a,
   output reg  [DW-1:0] rdata_a_ff,
   // Read port for the drive engine
   input  wire [AW-1:0] raddr_b,
   output reg  [DW-1:0] rdata_b_ff
);

   reg [DW-1:0] mem_ff [0:(1<<AW)-1];  // Storage, no reset needed

   // A read of a word being written sees old data
   always @(posedge sys_clk) begin
      if (we) begin
         mem_ff[waddr] <= wdata;
      end
      rdata_a_ff <= mem_ff[raddr_a];
      rdata_b_ff <= mem_ff[raddr_b];
   end

endmodule // fdcx_byte_mem

// [logic/fdcx_consts.vh]
// Constants for the floppy command interpreter: offsets, fields,
// opcode patterns, byte counts and store layout.
// Assumes inclusion by bare name.
`ifndef FDCX_CONSTS_VH
`define FDCX_CONSTS_VH

// Register word index, address bits [4:2]
`define FDCX_REG_DATA      3'h0
`define FDCX_REG_STATUS    3'h1
`define FDCX_REG_IRQ_STAT  3'h2
`define FDCX_REG_IRQ_MASK  3'h3

// Status register bit positions
`define FDCX_ST_RQM        7
`define FDCX_ST_DIO        6
`define FDCX_ST_EXEC       5
`define FDCX_ST_BUSY       4

// Interrupt event bit positions
`define FDCX_IRQ_RESULT    0
`define FDCX_IRQ_BADCMD    1
`define FDCX_IRQ_DONE      2
`define FDCX_IRQ_W         3

// Internal command codes
`define FDCX_CMD_NONE      3'h0
`define FDCX_CMD_READ_ID   3'h1
`define FDCX_CMD_VERIFY    3'h2
`define FDCX_CMD_VERSION   3'h3
`define FDCX_CMD_WRITE     3'h4
`define FDCX_CMD_WRITE_DEL 3'h5

// Opcode masks and patterns
`define FDCX_OPM_READ_ID   8'hbf
`define FDCX_OPV_READ_ID   8'h0a
`define FDCX_OPM_VERIFY    8'h1f
`define FDCX_OPV_VERIFY    8'h16
`define FDCX_OPV_VERSION   8'h10
`define FDCX_OPM_WRITE     8'h3f
`define FDCX_OPV_WRITE     8'h05
`define FDCX_OPV_WRITE_DEL 8'h09

// Opcode and select field positions
`define FDCX_B_MULTI_TRACK 7
`define FDCX_B_DENSITY     6
`define FDCX_B_SKIP_DEL    5
`define FDCX_B_COUNT_EN    7
`define FDCX_B_HEAD        2

// Byte counts per phase
`define FDCX_LEN_READ_ID   4'h2
`define FDCX_LEN_FULL      4'h9
`define FDCX_LEN_VERSION   4'h1
`define FDCX_RES_FULL      4'h7
`define FDCX_RES_VERSION   4'h1

// Byte store: command bytes from 0, results from 9
`define FDCX_CMD_BASE      4'h0
`define FDCX_RES_BASE      4'h9

`endif

// [logic/fdcx_ctrl.v]
// Command phase sequencer of a floppy controller for Read ID, Verify,
// Version, Write Data and Write Deleted Data, behind an Avalon-MM slave.
// Assumes a drive engine on sys_clk runs the execution phase.
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "fdcx_consts.vh"

// Summary of operation
// [R1] Read ID: two bytes, then capture ID
// [R2] Read ID offers seven result bytes in order
// [R3] Verify: host writes nine command bytes
// [R4] Verify execution moves no sector data
// [R5] Verify returns three status plus ID bytes
// [R6] Version returns one byte, no execution
// [R7] Write Data: nine bytes, data out, results
// [R8] Write Deleted: same layout, other opcode
// [R9] Execute after last byte; idle after results
module fdcx_ctrl #(
   parameter [7:0] VERSION_ID = 8'h5a   // Arbitrary identity value
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // Avalon-MM slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [3:0]  avs_byteenable,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata_ff,
   output reg         avs_waitrequest_ff,
   // Interrupt
   output wire        irq_ff,
   // Drive engine command side
   output reg         exec_go_ff,
   output reg  [2:0]  exec_cmd_ff,
   output reg         multi_track_flag_ff,
   output reg         density_flag_ff,
   output reg         skip_deleted_flag_ff,
   output reg         count_enable_flag_ff,
   output reg         head_select_ff,
   output reg         drive_select_hi_ff,
   output reg         drive_select_lo_ff,
   input  wire [3:0]  par_rd_idx,
   output wire [7:0]  par_rd_data_ff,
   // Drive engine sector data toward the drive
   output reg  [7:0]  wr_data_ff,
   output reg         wr_valid_ff,
   input  wire        wr_ready,
   // Drive engine completion and result bytes
   input  wire        exec_done,
   input  wire [7:0]  result_status_a,
   input  wire [7:0]  result_status_b,
   input  wire [7:0]  result_status_c,
   input  wire [7:0]  id_cylinder,
   input  wire [7:0]  id_head,
   input  wire [7:0]  id_sector,
   input  wire [7:0]  id_size
);

   // Phase states
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD  = 3'h1;
   localparam ST_EXEC = 3'h2;
   localparam ST_LOAD = 3'h3;
   localparam ST_RES  = 3'h4;

   // Bus access states
   localparam AC_IDLE = 2'h0;
   localparam AC_WAIT = 2'h1;
   localparam AC_ACK  = 2'h2;

   // Opcode decoder for the first byte
   function [2:0] dec_cmd(input [7:0] b);
      begin
         if ((b & `FDCX_OPM_READ_ID) == `FDCX_OPV_READ_ID)
            dec_cmd = `FDCX_CMD_READ_ID;              // [R1]
         else if ((b & `FDCX_OPM_VERIFY) == `FDCX_OPV_VERIFY)
            dec_cmd = `FDCX_CMD_VERIFY;               // [R3]
         else if (b == `FDCX_OPV_VERSION)
            dec_cmd = `FDCX_CMD_VERSION;              // [R6]
         else if ((b & `FDCX_OPM_WRITE) == `FDCX_OPV_WRITE)
            dec_cmd = `FDCX_CMD_WRITE;                // [R7]
         else if ((b & `FDCX_OPM_WRITE) == `FDCX_OPV_WRITE_DEL)
            dec_cmd = `FDCX_CMD_WRITE_DEL;            // [R8]
         else
            dec_cmd = `FDCX_CMD_NONE;
      end
   endfunction

   // Command bytes per command
   function [3:0] cmd_len(input [2:0] c);
      begin
         case (c)
            `FDCX_CMD_READ_ID: cmd_len = `FDCX_LEN_READ_ID;
            `FDCX_CMD_VERSION: cmd_len = `FDCX_LEN_VERSION;
            default:           cmd_len = `FDCX_LEN_FULL;
         endcase
      end
   endfunction

   reg  [2:0]  st_ff;          // Phase state
   reg  [2:0]  cmd_ff;         // Command being run
   reg  [3:0]  len_ff;         // Command bytes expected
   reg  [3:0]  res_len_ff;     // Result bytes to offer
   reg  [3:0]  idx_ff;         // Byte index in phase
   reg  [1:0]  acc_st_ff;      // Bus access state
   reg  [31:0] rd_mux;         // Read data by address
   reg         mem_we;         // Byte store write strobe
   reg  [3:0]  mem_waddr;      // Byte store write address
   reg  [7:0]  mem_wdata;      // Byte store write data
   reg  [7:0]  res_byte;       // Result byte to load
   reg  [`FDCX_IRQ_W-1:0] evt; // Interrupt event pulses

   wire [7:0]  wbyte;          // Low byte of bus write data
   wire [2:0]  reg_sel;        // Word index of the access
   wire        req;            // Bus request present
   wire        acc_done;       // Answer edge
   wire        host_wr;        // Write lands now
   wire        data_wr;        // Write to the data register
   wire        data_rd;        // Read of the data register
   wire        is_write_cmd;   // Command streams to drive
   wire        stall;          // Hold data write, stream full
   wire [7:0]  res_q;          // Result at read pointer
   wire [2:0]  dc;             // Decode of the incoming byte
   wire [`FDCX_IRQ_W-1:0] irq_stat;
   wire [`FDCX_IRQ_W-1:0] irq_mask;

   assign wbyte    = avs_writedata[7:0];
   assign reg_sel  = avs_address[4:2];
   assign req      = avs_read | avs_write;
   assign acc_done = (acc_st_ff == AC_ACK);
   assign host_wr  = acc_done & avs_write & avs_byteenable[0];
   assign data_wr  = host_wr & (reg_sel == `FDCX_REG_DATA);
   assign data_rd  = acc_done & avs_read & (reg_sel == `FDCX_REG_DATA);
   assign dc       = dec_cmd(wbyte);
   assign is_write_cmd = (cmd_ff == `FDCX_CMD_WRITE) |
                         (cmd_ff == `FDCX_CMD_WRITE_DEL);
   // Sector byte waits for the drive to take the last
   assign stall    = avs_write & (reg_sel == `FDCX_REG_DATA) &
                     (st_ff == ST_EXEC) & is_write_cmd & wr_valid_ff;

   // Read mux; data register reads zero outside results
   always @* begin
      rd_mux = 32'h0;
      case (reg_sel)
         `FDCX_REG_DATA: begin
            if (st_ff == ST_RES)
               rd_mux = {24'h0, res_q};
         end
         `FDCX_REG_STATUS: begin
            rd_mux[`FDCX_ST_RQM]  = (st_ff == ST_IDLE) | (st_ff == ST_CMD) |
                                    (st_ff == ST_RES) |
                                    ((st_ff == ST_EXEC) & is_write_cmd &
                                     ~wr_valid_ff);
            rd_mux[`FDCX_ST_DIO]  = (st_ff == ST_RES);
            rd_mux[`FDCX_ST_EXEC] = (st_ff == ST_EXEC);
            rd_mux[`FDCX_ST_BUSY] = (st_ff != ST_IDLE);
            rd_mux[2:0]           = cmd_ff;
         end
         `FDCX_REG_IRQ_STAT: rd_mux = {29'h0, irq_stat};
         `FDCX_REG_IRQ_MASK: rd_mux = {29'h0, irq_mask};
         default: rd_mux = 32'h0;
      endcase
   end

   // Bus handshake: at least two wait cycles, one answer cycle
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_st_ff          <= AC_IDLE;
         avs_waitrequest_ff <= 1'b1;
         avs_readdata_ff    <= 32'h0;
      end else begin
         case (acc_st_ff)
            AC_IDLE: begin
               if (req)
                  acc_st_ff <= AC_WAIT;
            end
            AC_WAIT: begin
               if (!stall) begin
                  acc_st_ff          <= AC_ACK;
                  avs_waitrequest_ff <= 1'b0;
                  avs_readdata_ff    <= avs_read ? rd_mux : 32'h0;
               end
            end
            AC_ACK: begin
               acc_st_ff          <= AC_IDLE;
               avs_waitrequest_ff <= 1'b1;
            end
            default: begin
               acc_st_ff          <= AC_IDLE;
               avs_waitrequest_ff <= 1'b1;
            end
         endcase
      end
   end

   // Result byte for the load phase, status first
   always @* begin
      case (idx_ff)
         4'h0:    res_byte = result_status_a;              // [R2] [R5]
         4'h1:    res_byte = result_status_b;
         4'h2:    res_byte = result_status_c;
         4'h3:    res_byte = id_cylinder;
         4'h4:    res_byte = id_head;
         4'h5:    res_byte = id_sector;
         4'h6:    res_byte = id_size;
         default: res_byte = 8'h0;
      endcase
   end

   // Store writes: host command bytes, results on load
   always @* begin
      mem_we    = 1'b0;
      mem_waddr = `FDCX_CMD_BASE;
      mem_wdata = wbyte;
      evt       = {`FDCX_IRQ_W{1'b0}};
      if (data_wr && ((st_ff == ST_CMD) ||
                      ((st_ff == ST_IDLE) && (dc != `FDCX_CMD_NONE)))) begin
         mem_we    = 1'b1;
         mem_waddr = (st_ff == ST_CMD) ? idx_ff : `FDCX_CMD_BASE;
      end else if (st_ff == ST_LOAD) begin
         mem_we    = 1'b1;
         mem_waddr = `FDCX_RES_BASE + idx_ff;
         mem_wdata = (cmd_ff == `FDCX_CMD_VERSION) ? VERSION_ID :
                     res_byte;                                   // [R6]
      end
      evt[`FDCX_IRQ_BADCMD] = data_wr & (st_ff == ST_IDLE) &
                              (dc == `FDCX_CMD_NONE);
      evt[`FDCX_IRQ_DONE]   = (st_ff == ST_EXEC) & exec_done;
      evt[`FDCX_IRQ_RESULT] = (st_ff == ST_LOAD) &
                              (idx_ff == res_len_ff - 4'h1);
   end

   // Phase sequencer
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff                <= ST_IDLE;
         cmd_ff               <= `FDCX_CMD_NONE;
         len_ff               <= 4'h0;
         res_len_ff           <= 4'h0;
         idx_ff               <= 4'h0;
         exec_go_ff           <= 1'b0;
         exec_cmd_ff          <= `FDCX_CMD_NONE;
         multi_track_flag_ff  <= 1'b0;
         density_flag_ff      <= 1'b0;
         skip_deleted_flag_ff <= 1'b0;
         count_enable_flag_ff <= 1'b0;
         head_select_ff       <= 1'b0;
         drive_select_hi_ff   <= 1'b0;
         drive_select_lo_ff   <= 1'b0;
      end else begin
         exec_go_ff <= 1'b0;
         case (st_ff)
            ST_IDLE: begin
               // Unknown opcodes raise an event, then drop
               if (data_wr && (dc != `FDCX_CMD_NONE)) begin
                  cmd_ff               <= dc;
                  len_ff               <= cmd_len(dc);
                  idx_ff               <= 4'h1;
                  multi_track_flag_ff  <= wbyte[`FDCX_B_MULTI_TRACK];
                  density_flag_ff      <= wbyte[`FDCX_B_DENSITY];
                  skip_deleted_flag_ff <= wbyte[`FDCX_B_SKIP_DEL];
                  if (dc == `FDCX_CMD_VERSION) begin
                     st_ff      <= ST_LOAD;                      // [R6]
                     idx_ff     <= 4'h0;
                     res_len_ff <= `FDCX_RES_VERSION;
                  end else begin
                     st_ff      <= ST_CMD;
                     res_len_ff <= `FDCX_RES_FULL;
                  end
               end
            end
            ST_CMD: begin
               if (data_wr) begin
                  idx_ff <= idx_ff + 4'h1;
                  if (idx_ff == 4'h1) begin
                     count_enable_flag_ff <= wbyte[`FDCX_B_COUNT_EN]; // [R3]
                     head_select_ff       <= wbyte[`FDCX_B_HEAD];
                     drive_select_hi_ff   <= wbyte[1];
                     drive_select_lo_ff   <= wbyte[0];
                  end
                  // Execution starts only once the last byte is in
                  if (idx_ff == len_ff - 4'h1) begin
                     st_ff       <= ST_EXEC;                     // [R9]
                     exec_go_ff  <= 1'b1;
                     exec_cmd_ff <= cmd_ff;
                  end
               end
            end
            ST_EXEC: begin
               // Engine done; ID bytes are copied into the store in the load phase that follows
               if (exec_done) begin
                  st_ff  <= ST_LOAD;                             // [R1]
                  idx_ff <= 4'h0;
               end
            end
            ST_LOAD: begin
               idx_ff <= idx_ff + 4'h1;
               if (idx_ff == res_len_ff - 4'h1) begin
                  st_ff  <= ST_RES;                              // [R2]
                  idx_ff <= 4'h0;
               end
            end
            ST_RES: begin
               // New commands wait until every result is read
               if (data_rd) begin
                  idx_ff <= idx_ff + 4'h1;
                  if (idx_ff == res_len_ff - 4'h1) begin
                     st_ff  <= ST_IDLE;                          // [R9]
                     cmd_ff <= `FDCX_CMD_NONE;
                  end
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // Sector stream to the drive; only write commands feed it,
   // so data writes in other execution phases drop
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_data_ff  <= 8'h0;
         wr_valid_ff <= 1'b0;
      end else begin
         if (wr_valid_ff && wr_ready)
            wr_valid_ff <= 1'b0;
         if (data_wr && (st_ff == ST_EXEC) && is_write_cmd) begin
            wr_data_ff  <= wbyte;                                // [R7] [R8]
            wr_valid_ff <= 1'b1;
         end
         // Verify data has no path either way   // [R4]
      end
   end

   // Byte store for command and result bytes
   fdcx_byte_mem #(
      .AW (4),
      .DW (8)
   ) u_mem (
      .sys_clk    (sys_clk),
      .we         (mem_we),
      .waddr      (mem_waddr),
      .wdata      (mem_wdata),
      .raddr_a    (`FDCX_RES_BASE + idx_ff),
      .rdata_a_ff (res_q),
      .raddr_b    (par_rd_idx),
      .rdata_b_ff (par_rd_data_ff)
   );

   // Interrupt status and mask
   fdcx_irq u_irq (
      .sys_clk (sys_clk),
      .rst     (rst),
      .set_evt (evt),
      .clr_we  (host_wr & (reg_sel == `FDCX_REG_IRQ_STAT)),
      .mask_we (host_wr & (reg_sel == `FDCX_REG_IRQ_MASK)),
      .wr_data (avs_writedata[`FDCX_IRQ_W-1:0]),
      .stat_ff (irq_stat),
      .mask_ff (irq_mask),
      .irq_ff  (irq_ff)
   );

endmodule // fdcx_ctrl

// [logic/fdcx_irq.v]
// Sticky interrupt status with write-one-to-clear and a mask.
// Assumes all inputs on sys_clk.
`timescale 1ns/10ps
`include "fdcx_consts.vh"
module fdcx_irq (
   // Clock and reset
   input  wire                   sys_clk,
   input  wire                   rst,
   // Events
   input  wire [`FDCX_IRQ_W-1:0] set_evt,
   // Software access
   input  wire                   clr_we,
   input  wire                   mask_we,
   input  wire [`FDCX_IRQ_W-1:0] wr_data,
   // State
   output reg  [`FDCX_IRQ_W-1:0] stat_ff,
   output reg  [`FDCX_IRQ_W-1:0] mask_ff,
   output reg                    irq_ff
);

   wire [`FDCX_IRQ_W-1:0] clr_bits;      // Bits software clears now
   wire [`FDCX_IRQ_W-1:0] nxt_stat;      // Next sticky status
   wire [`FDCX_IRQ_W-1:0] nxt_mask;      // Next mask

   assign clr_bits = clr_we ? wr_data : {`FDCX_IRQ_W{1'b0}};
   // A set in the clearing cycle wins so no event is lost
   assign nxt_stat = (stat_ff & ~clr_bits) | set_evt;
   assign nxt_mask = mask_we ? wr_data : mask_ff;

   // Output flop fed by next values, so it is prompt
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_ff <= {`FDCX_IRQ_W{1'b0}};
         mask_ff <= {`FDCX_IRQ_W{1'b0}};
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff  <= |(nxt_stat & nxt_mask);
      end
   end

endmodule // fdcx_irq

// [verif/fdcx_chk.sv]
// Concurrent checks on the floppy command sequencer's ports.
// Assumes one clock domain, sys_clk, with rst as its reset.
`timescale 1ns/10ps
`include "fdcx_consts.vh"
module fdcx_chk (
   // Clock and reset
   input wire       sys_clk,
   input wire       rst,
   // Bus handshake
   input wire       avs_read,
   input wire       avs_write,
   input wire       avs_waitrequest_ff,
   // Engine side
   input wire       exec_go_ff,
   input wire [2:0] exec_cmd_ff,
   input wire       wr_valid_ff,
   input wire [7:0] wr_data_ff,
   input wire       wr_ready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Write taken at this edge
   wire take_w = avs_write && !avs_waitrequest_ff;
   // Start of a read request
   sequence s_rd_start;
      $rose(avs_read);
   endsequence
   // Answer within four edges
   sequence s_answer;
      ##[1:4] !avs_waitrequest_ff;
   endsequence
   a_go_pulse: assert property (exec_go_ff |=> !exec_go_ff)
      else $error("start pulse too long");
   a_go_after_take: assert property (
      exec_go_ff |-> $past(take_w) || $past(take_w, 2))
      else $error("start without a byte write");
   a_go_cmd_known: assert property (exec_go_ff |->
      exec_cmd_ff inside {`FDCX_CMD_READ_ID, `FDCX_CMD_VERIFY,
                          `FDCX_CMD_WRITE, `FDCX_CMD_WRITE_DEL})
      else $error("start with a bad command");
   a_stream_cmd: assert property (wr_valid_ff |->
      exec_cmd_ff inside {`FDCX_CMD_WRITE, `FDCX_CMD_WRITE_DEL})
      else $error("sector byte outside a write");
   a_stream_hold: assert property (wr_valid_ff && !wr_ready |=>
      wr_valid_ff && $stable(wr_data_ff))
      else $error("sector byte lost");
   a_rd_answer: assert property (s_rd_start |-> s_answer)
      else $error("read not answered in time");
   a_wait_one: assert property (
      !avs_waitrequest_ff |=> avs_waitrequest_ff)
      else $error("answer too long");
   a_idle_wait: assert property (
      !(avs_read || avs_write) |-> avs_waitrequest_ff)
      else $error("answer without a request");
endmodule // fdcx_chk

bind fdcx_ctrl fdcx_chk fdcx_chk_inst (.sys_clk, .rst, .avs_read,
   .avs_write, .avs_waitrequest_ff, .exec_go_ff, .exec_cmd_ff,
   .wr_valid_ff, .wr_data_ff, .wr_ready);

// [verif/fdcx_ctrl_tb.sv]
// Self-checking bench of the floppy command sequencer.
// Assumes fdcx_eng stands in for the drive engine.
`timescale 1ns/10ps
`include "fdcx_consts.vh"
`define CHK(n, e, g) begin \
   compares = compares + 1; \
   if ((g) !== (e)) begin \
      fail_count = fail_count + 1; \
      $display("wrong value %s exp %h got %h", n, e, g); \
   end \
end
module fdcx_ctrl_tb;
   reg         sys_clk, rst, avs_read, avs_write, stall;
   reg  [4:0]  avs_address;
   reg  [31:0] avs_writedata, q;  // Bus data, last read
   wire [31:0] avs_readdata_ff;
   wire        avs_waitrequest_ff, irq_ff, exec_go_ff, exec_done;
   wire [2:0]  exec_cmd_ff;
   wire        multi_track_flag_ff, density_flag_ff;
   wire        skip_deleted_flag_ff, count_enable_flag_ff;
   wire        head_select_ff, drive_select_hi_ff, drive_select_lo_ff;
   wire [3:0]  par_rd_idx;
   wire [7:0]  par_rd_data_ff, wr_data_ff;
   wire        wr_valid_ff, wr_ready;
   wire [55:0] res_bus;
   reg  [55:0] res;               // Engine result bytes
   reg  [3:0]  n_wr;              // Stream length for the engine
   reg  [7:0]  cb [0:8];          // Command bytes sent
   reg  [7:0]  wd [0:8];          // Sector bytes sent
   reg  [7:0]  exp_q [$];         // Expected result bytes, in order
   reg  [7:0]  e8;
   reg  [2:0]  ec;                // Expected command code
   integer     fail_count, compares, seed, i, k, nl;
   fdcx_ctrl #(.VERSION_ID(8'h3c)) fdcx_ctrl_inst (.*,
      .avs_byteenable(4'hf), .result_status_a(res_bus[55:48]),
      .result_status_b(res_bus[47:40]), .result_status_c(res_bus[39:32]),
      .id_cylinder(res_bus[31:24]), .id_head(res_bus[23:16]),
      .id_sector(res_bus[15:8]), .id_size(res_bus[7:0]));
   fdcx_eng fdcx_eng_inst (.*);
   // Random byte
   function [7:0] r8;
      reg [31:0] x;
      begin
         x = $random(seed);
         r8 = x[7:0];
      end
   endfunction
   // Verdict and end of run
   task report_and_stop;
      begin
         if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // One bus access, held until waitrequest is low
   task bus(input w, input [4:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge sys_clk);
         avs_write <= w;
         avs_read <= !w;
         avs_address <= a;
         avs_writedata <= {24'h0, d};
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
         end while (avs_waitrequest_ff !== 1'b0 && n < 300);
         if (n >= 300) fail_count = fail_count + 1;
         q = avs_readdata_ff;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end
   endtask
   // Poll status until the result phase
   task wait_res;
      integer n;
      begin
         n = 0;
         do begin
            bus(0, 5'h04, 8'h0);
            n = n + 1;
         end while (q[`FDCX_ST_DIO] !== 1'b1 && n < 100);
         if (q[`FDCX_ST_DIO] !== 1'b1) fail_count = fail_count + 1;
      end
   endtask
   // Clock of 100 ns
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Random engine stalls
   always @(posedge sys_clk) stall <= ^r8();
   // Hang guard
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count = fail_count + 1;
      report_and_stop;
   end
   // Main sequence
   initial begin
      seed = 32'h99ec;
      fail_count = 0;
      compares = 0;
      {rst, avs_read, avs_write} = 3'h4;
      {avs_address, avs_writedata, res, n_wr} = 97'h0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      bus(0, 5'h10, 8'h0);
      `CHK("unmapped", 32'h0, q)
      bus(1, 5'h0c, 8'h07);
      bus(0, 5'h0c, 8'h0);
      `CHK("mask", 3'h7, q[2:0])
      bus(1, 5'h00, 8'h00);
      bus(0, 5'h08, 8'h0);
      `CHK("bad opcode", 1'b1, q[`FDCX_IRQ_BADCMD])
      bus(1, 5'h00, `FDCX_OPV_VERSION);
      wait_res;
      `CHK("irq on", 1'b1, irq_ff)
      bus(0, 5'h00, 8'h0);
      `CHK("version", 8'h3c, q[7:0])
      // Read ID, Verify, Write and Write Deleted twice each, mask off on even passes
      for (k = 0; k < 8; k = k + 1) begin
         bus(1, 5'h08, 8'h07);
         bus(1, 5'h0c, {5'h0, {3{k[0]}}});
         for (i = 0; i < 9; i = i + 1) cb[i] = r8();
         for (i = 0; i < 9; i = i + 1) wd[i] = r8();
         cb[1] = cb[1] & ((k % 4 == 1) ? 8'h87 : 8'h07);
         case (k % 4)
            0: begin
               cb[0] = {1'b0, cb[0][6], 6'h0a};
               ec = `FDCX_CMD_READ_ID;
            end
            1: begin
               cb[0] = {cb[0][7:5], 5'h16};
               ec = `FDCX_CMD_VERIFY;
            end
            2: begin
               cb[0] = {cb[0][7:6], 6'h05};
               ec = `FDCX_CMD_WRITE;
            end
            default: begin
               cb[0] = {cb[0][7:6], 6'h09};
               ec = `FDCX_CMD_WRITE_DEL;
            end
         endcase
         for (i = 0; i < 7; i = i + 1) begin
            e8 = r8();
            exp_q.push_back(e8);
            res = {res[47:0], e8};
         end
         n_wr = k[3:0] + 4'h1;
         fdcx_eng_inst.got.delete();
         nl = (k % 4 == 0) ? 2 : 9;
         for (i = 0; i < nl; i = i + 1) bus(1, 5'h00, cb[i]);
         if (ec[2]) for (i = 0; i < n_wr; i = i + 1) bus(1, 5'h00, wd[i]);
         else bus(0, 5'h00, 8'h0);
         if (!ec[2]) `CHK("exec read", 8'h0, q[7:0])
         wait_res;
         `CHK("irq", k[0], irq_ff)
         `CHK("cmd", ec, exec_cmd_ff)
         `CHK("flags", {cb[0][7:5], cb[1][7], cb[1][2:0]},
              {multi_track_flag_ff, density_flag_ff, skip_deleted_flag_ff,
               count_enable_flag_ff, head_select_ff, drive_select_hi_ff,
               drive_select_lo_ff})
         for (i = 0; i < nl; i = i + 1)
            `CHK("param", cb[i], fdcx_eng_inst.par[i])
         for (i = 0; i < n_wr && ec[2]; i = i + 1)
            `CHK("stream", wd[i], fdcx_eng_inst.got[i])
         if (!ec[2]) `CHK("no stream", 0, fdcx_eng_inst.got.size())
         for (i = 0; i < 7; i = i + 1) begin
            bus(0, 5'h00, 8'h0);
            e8 = exp_q.pop_front();
            `CHK("result", e8, q[7:0])
         end
         bus(0, 5'h04, 8'h0);
         `CHK("idle", 1'b0, q[`FDCX_ST_DIO])
      end
      report_and_stop;
   end
endmodule // fdcx_ctrl_tb

// [verif/fdcx_eng.sv]
// Behavioural drive engine on the sequencer's far side.
// Assumes the bench gives result bytes and stream length.
`timescale 1ns/10ps
module fdcx_eng (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // Command side
   input  wire        exec_go_ff,
   input  wire [2:0]  exec_cmd_ff,
   output reg  [3:0]  par_rd_idx,
   input  wire [7:0]  par_rd_data_ff,
   // Sector stream toward the drive
   input  wire [7:0]  wr_data_ff,
   input  wire        wr_valid_ff,
   output reg         wr_ready,
   input  wire        stall,
   // Completion and results
   output reg         exec_done,
   output reg  [55:0] res_bus,
   input  wire [55:0] res,
   input  wire [3:0]  n_wr
);
   reg [7:0] par [0:8];   // Command bytes read back
   reg [7:0] got [$];     // Sector bytes taken
   integer   i;           // Step counter
   // One execution per start pulse; reset mid-run is not modelled
   initial begin
      par_rd_idx = 4'h0;
      wr_ready = 1'b0;
      exec_done = 1'b0;
      res_bus = 56'h0;
      forever begin
         @(posedge sys_clk);
         if (exec_go_ff === 1'b1 && rst === 1'b0) begin
            // Store read port answers one cycle late
            for (i = 0; i < 10; i = i + 1) begin
               par_rd_idx <= (i > 8) ? 4'h8 : i[3:0];
               @(posedge sys_clk);
               if (i > 0) par[i-1] = par_rd_data_ff;
            end
            // Only the write commands stream, with random stalls
            if (exec_cmd_ff[2]) begin
               while (got.size() < n_wr) begin
                  wr_ready <= !stall;
                  @(posedge sys_clk);
                  if (wr_valid_ff && wr_ready) got.push_back(wr_data_ff);
               end
            end
            wr_ready <= 1'b0;
            res_bus <= res;
            exec_done <= 1'b1;
            @(posedge sys_clk);
            exec_done <= 1'b0;
            repeat (8) @(posedge sys_clk);
            // Results no longer valid
            res_bus <= ~res;
         end
      end
   end
endmodule // fdcx_eng
